/* tb/cpu_model.sv */
`timescale 1ns/1ns
// ============================================================
// Sequencer stand-in: acks vector requests, returns on command.
module cpu_model #(
    parameter int ACK_DELAY = 0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic hold_i,
    input wire logic ret_cmd_i,
    output logic ack_o,
    output logic ret_o,
    output logic instr_o
);
    int wait_cnt;
    // Ack is one pulse, so a standing request is taken once.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            ret_o <= 1'b0;
            instr_o <= 1'b0;
            wait_cnt <= 0;
        end else begin
            ret_o <= ret_cmd_i;
            instr_o <= ret_o;
            ack_o <= 1'b0;
            if (irq_req_i && !ack_o && !hold_i) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= ACK_DELAY) begin
                    ack_o <= 1'b1;
                    wait_cnt <= 0;
                end
            end
        end
    end
endmodule

/* tb/irq_ctrl_monitor.sv */
`timescale 1ns/1ns
module irq_ctrl_monitor
    import irq_ctrl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire sfr_req_s sfr_i,
    input wire logic [PIN_COUNT-1:0] port_pins_i,
    input wire logic [SRC_COUNT-1:0] periph_pending_i,
    input wire logic [SRC_COUNT-1:0] src_enable_i,
    input wire logic cpu_vector_ack_i,
    input wire logic cpu_return_done_i,
    input wire logic cpu_instr_done_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic irq_req_o,
    input wire logic [SRC_IDX_W-1:0] irq_vec_o,
    input wire logic irq_high_o,
    input wire logic [1:0] in_service_o,
    input wire logic [1:0] ext_pending_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ============================================================
    // Helper state
    // The return hold is rebuilt here because the design keeps it internal.
    logic ret_hold;
    logic [SRC_COUNT-1:0] live;
    assign live = periph_pending_i & src_enable_i & 16'hFFFA;
    always_ff @(posedge core_clk_i) begin
        ret_hold <= !rst_i && !cpu_instr_done_i && (ret_hold || cpu_return_done_i);
    end
    // ============================================================
    // Properties
    sequence s_ack;
        irq_req_o && cpu_vector_ack_i;
    endsequence
    sequence s_idle_live;
        !irq_req_o && in_service_o == 2'b00 && !ret_hold && !cpu_return_done_i && live != '0;
    endsequence
    a_prio_top_one: assert property (sfr_i.rd && sfr_i.addr == 8'hB8 |=> sfr_rdata_o[7])
        else $error("priority register top bit read as zero");
    a_ack_takes_req: assert property (s_ack |=> !irq_req_o && in_service_o != 2'b00)
        else $error("vector ack did not move request into service");
    a_ack_sets_level: assert property (s_ack |=> in_service_o[$past(irq_high_o)])
        else $error("service level differs from requested level");
    a_high_never_preempted: assert property (in_service_o[1] |-> !irq_req_o)
        else $error("request raised during high handler");
    a_low_needs_high: assert property (in_service_o[0] && irq_req_o |-> irq_high_o)
        else $error("low request raised during low handler");
    a_return_holds_off: assert property (ret_hold |-> !irq_req_o)
        else $error("request before the instruction after return");
    a_fast_detect: assert property (s_idle_live |=> irq_req_o)
        else $error("eligible source not requested after one cycle");
    a_tie_lowest_index: assert property ($stable(live) && !$past(sfr_i.wr)
        && !$past(sfr_i.bit_wr) && irq_req_o && !irq_high_o && in_service_o == 2'b00
        |-> (live & ((16'h0001 << irq_vec_o) - 16'h0001)) == 16'h0000)
        else $error("low request did not pick lowest index");
endmodule
bind two_level_interrupt_controller irq_ctrl_monitor u_irq_ctrl_monitor (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_i(sfr_i), .port_pins_i(port_pins_i),
    .periph_pending_i(periph_pending_i), .src_enable_i(src_enable_i),
    .cpu_vector_ack_i(cpu_vector_ack_i), .cpu_return_done_i(cpu_return_done_i),
    .cpu_instr_done_i(cpu_instr_done_i), .sfr_rdata_o(sfr_rdata_o), .irq_req_o(irq_req_o),
    .irq_vec_o(irq_vec_o), .irq_high_o(irq_high_o), .in_service_o(in_service_o),
    .ext_pending_o(ext_pending_o));

/* tb/test_two_level_interrupt_controller.sv */
`timescale 1ns/1ns
module test_two_level_interrupt_controller
    import irq_ctrl_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    sfr_req_s sfr = '0;
    logic [7:0] pins = 8'hDF;
    logic [15:0] pend = 16'h0000;
    logic [15:0] en = 16'hFFFF;
    logic hold = 1'b0;
    logic ret_cmd = 1'b0;
    logic ack, rdone, idone, irq_req_o, irq_high_o;
    logic [7:0] sfr_rdata_o, rd_v;
    logic [3:0] irq_vec_o;
    logic [1:0] in_service_o, ext_pending_o;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    // Rows: pending[31:16], priority byte[15:8], vector[7:4], high level[0].
    logic [31:0] rows [9] = '{32'h0002_8010, 32'h000A_8010, 32'h000A_8831, 32'h000A_8211,
        32'h0050_C061, 32'h0030_A051, 32'h0012_9041, 32'h0082_8010, 32'h8000_80F0};
    two_level_interrupt_controller u_two_level_interrupt_controller (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_i(sfr), .port_pins_i(pins),
        .periph_pending_i(pend), .src_enable_i(en), .cpu_vector_ack_i(ack),
        .cpu_return_done_i(rdone), .cpu_instr_done_i(idone), .sfr_rdata_o(sfr_rdata_o),
        .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o), .irq_high_o(irq_high_o),
        .in_service_o(in_service_o), .ext_pending_o(ext_pending_o));
    cpu_model u_cpu_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
        .hold_i(hold), .ret_cmd_i(ret_cmd), .ack_o(ack), .ret_o(rdone), .instr_o(idone));
    always #2 core_clk_i = ~core_clk_i;
    // ============================================================
    // Tasks
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // The run needs about 200 cycles; the limit leaves ample room.
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic sfr_op(input logic [7:0] a, input logic [7:0] pg, input logic w,
        input logic [7:0] d);
        tk(1);
        sfr.addr = a;
        sfr.page = pg;
        sfr.wdata = d;
        sfr.wr = w;
        sfr.rd = !w;
        tk(1);
        sfr.wr = 1'b0;
        sfr.rd = 1'b0;
        rd_v = sfr_rdata_o;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] pg,
        input logic [7:0] e);
        sfr_op(a, pg, 1'b0, 8'h00);
        chk(nm, e, rd_v);
    endtask
    task automatic bw(input logic [7:0] a, input logic [2:0] idx, input logic v);
        tk(1);
        sfr.addr = a;
        sfr.bit_idx = idx;
        sfr.bit_val = v;
        sfr.bit_wr = 1'b1;
        tk(1);
        sfr.bit_wr = 1'b0;
    endtask
    task automatic wait_req(output int c);
        c = 0;
        do begin
            tk(1);
            c++;
        end while (irq_req_o !== 1'b1 && c < 40);
    endtask
    task automatic do_ret();
        tk(1);
        ret_cmd = 1'b1;
        tk(1);
        ret_cmd = 1'b0;
        tk(3);
    endtask
    task automatic tk(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    // ============================================================
    // Sequence
    initial begin
        tk(6);
        rst_i = 1'b0;
        for (int i = 0; i < 9; i++) begin
            sfr_op(ADDR_SOURCE_PRIO, 8'h00, 1'b1, rows[i][15:8]);
            pend = rows[i][31:16];
            wait_req(n);
            chk("detect", 8'(DETECT_CYCLES), 8'(n));
            chk("vector", {4'h0, rows[i][7:4]}, {4'h0, irq_vec_o});
            chk("level", {7'h0, rows[i][0]}, {7'h0, irq_high_o});
            tk(3);
            chk("service", {6'h0, rows[i][0], !rows[i][0]}, {6'h0, in_service_o});
            pend = 16'h0000;
            do_ret();
        end
        $display("test arbitration rows done");
        rst_i = 1'b1;
        tk(2);
        rst_i = 1'b0;
        rd_chk("prio reset", ADDR_SOURCE_PRIO, 8'h00, 8'h80);
        rd_chk("cfg reset", ADDR_EXT_INPUT_CFG, PAGE_EXT_INPUT_CFG, 8'h01);
        rd_chk("timer_control_reg reset", ADDR_TIMER_CONTROL, 8'h00, 8'h00);
        rd_chk("unmapped", 8'h00, 8'h00, 8'h00);
        sfr_op(ADDR_SOURCE_PRIO, 8'h00, 1'b1, 8'h7F);
        rd_chk("prio page", ADDR_SOURCE_PRIO, PAGE_EXT_INPUT_CFG, 8'hFF);
        bw(ADDR_SOURCE_PRIO, 3'd7, 1'b0);
        bw(ADDR_SOURCE_PRIO, 3'd3, 1'b0);
        rd_chk("prio bits", ADDR_SOURCE_PRIO, 8'h00, 8'hF7);
        sfr_op(ADDR_SOURCE_PRIO, 8'h00, 1'b1, 8'h00);
        $display("test registers done");
        sfr_op(ADDR_EXT_INPUT_CFG, PAGE_EXT_INPUT_CFG, 1'b1, 8'h2D);
        sfr_op(ADDR_TIMER_CONTROL, 8'h00, 1'b1, 8'h05);
        hold = 1'b1;
        pins = 8'hCF;
        tk(2);
        pins = 8'hDF;
        tk(2);
        chk("other pin", 8'h00, {6'h0, ext_pending_o});
        pins = 8'hFF;
        tk(2);
        pins = 8'hDF;
        tk(2);
        chk("edge latch", 8'h01, {6'h0, ext_pending_o});
        wait_req(n);
        chk("ext0 vec", 8'h00, {4'h0, irq_vec_o});
        hold = 1'b0;
        tk(4);
        chk("edge clear", 8'h00, {6'h0, ext_pending_o});
        do_ret();
        sfr_op(ADDR_TIMER_CONTROL, 8'h00, 1'b1, 8'h01);
        hold = 1'b1;
        pins = 8'hDB;
        tk(2);
        chk("level on", 8'h02, {6'h0, ext_pending_o});
        pins = 8'hDF;
        tk(2);
        chk("level off", 8'h00, {6'h0, ext_pending_o});
        pins = 8'hDB;
        wait_req(n);
        chk("ext1 vec", 8'h02, {4'h0, irq_vec_o});
        hold = 1'b0;
        tk(4);
        pins = 8'hDF;
        do_ret();
        bw(ADDR_TIMER_CONTROL, 3'd1, 1'b1);
        wait_req(n);
        chk("soft vec", 8'h00, {4'h0, irq_vec_o});
        chk("soft flag", 8'h01, {6'h0, ext_pending_o});
        tk(3);
        do_ret();
        $display("test external inputs done");
        sfr_op(ADDR_SOURCE_PRIO, 8'h00, 1'b1, 8'h88);
        pend = 16'h0002;
        tk(4);
        pend = 16'h000A;
        wait_req(n);
        chk("preempt vec", 8'h03, {4'h0, irq_vec_o});
        chk("preempt high", 8'h01, {7'h0, irq_high_o});
        tk(3);
        chk("nested", 8'h03, {6'h0, in_service_o});
        pend = 16'h0010;
        tk(3);
        chk("blocked", 8'h00, {7'h0, irq_req_o});
        do_ret();
        chk("unnest", 8'h01, {6'h0, in_service_o});
        chk("low blocked", 8'h00, {7'h0, irq_req_o});
        pend = 16'h0000;
        do_ret();
        en = 16'hFFFD;
        pend = 16'h0002;
        tk(3);
        chk("disabled", 8'h00, {7'h0, irq_req_o});
        pend = 16'h0000;
        $display("test preemption done");
        results();
    end
endmodule

/* verilog/ext_input_detect.sv */
`timescale 1ns/1ns
module ext_input_detect
    import irq_ctrl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [PIN_COUNT-1:0] port_pins_i,
    input wire ext_cfg_s cfg_i,
    input wire logic sw_write_i,
    input wire logic sw_value_i,
    input wire logic vector_clr_i,
    output logic pending_o
);

    typedef struct packed {
        logic prev_active;
        logic pending;
    } det_state_s;

    det_state_s state;
    det_state_s next_state;
    logic active;

    // ==========================================================
    // Pin watch: the pin is only read, so whatever drives it is undisturbed.
    assign active = (port_pins_i[cfg_i.pin_sel] == cfg_i.polarity); // [RULE_15] [RULE_21] [RULE_13]

    always_comb begin
        next_state = state;
        next_state.prev_active = active;
        if (cfg_i.edge_sel) begin
            if (vector_clr_i) begin
                next_state.pending = 1'b0; // [RULE_17]
            end
            if (sw_write_i) begin
                next_state.pending = sw_value_i;
            end
            // A fresh edge wins over any clear in the same cycle.
            if (active && !state.prev_active) begin
                next_state.pending = 1'b1; // [RULE_14]
            end
        end else begin
            next_state.pending = active; // [RULE_18] [RULE_14]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pending_o = state.pending;

endmodule

/* verilog/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

    // ==========================================================
    // Sizes
    localparam int SRC_COUNT = 16;
    localparam int SRC_IDX_W = 4;
    localparam int PIN_COUNT = 8;

    // ==========================================================
    // Register addresses and pages
    localparam logic [7:0] ADDR_SOURCE_PRIO = 8'hB8;
    localparam logic [7:0] ADDR_EXT_INPUT_CFG = 8'hE4;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_EXTENDED_PRIO = 8'hF6;
    localparam logic [7:0] ADDR_EXTENDED_PRIO_B = 8'hF7;
    localparam logic [7:0] PAGE_EXT_INPUT_CFG = 8'h0F;

    // ==========================================================
    // Reset values and field positions
    localparam logic [7:0] SOURCE_PRIO_RESET = 8'h80;
    localparam logic [7:0] EXT_INPUT_CFG_RESET = 8'h01;
    localparam logic [7:0] EXTENDED_PRIO_RESET = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int PRIO_UNUSED_BIT = 7;
    localparam int PRIO_USED_BITS = 7;
    localparam int EXTENDED_PRIO_BITS = 8;
    localparam int TIMER_CONTROL_REG_EXT_ZERO_EDGE_SEL = 0;
    localparam int TIMER_CONTROL_REG_EXT_ZERO_PENDING = 1;
    localparam int TIMER_CONTROL_REG_EXT_ONE_EDGE_SEL = 2;
    localparam int TIMER_CONTROL_REG_EXT_ONE_PENDING = 3;
    localparam int CFG_ZERO_PIN_SEL_LSB = 0;
    localparam int CFG_ZERO_POLARITY = 3;
    localparam int CFG_ONE_PIN_SEL_LSB = 4;
    localparam int CFG_ONE_POLARITY = 7;

    // ==========================================================
    // Source numbering, lowest index wins a tie
    localparam logic [SRC_IDX_W-1:0] SRC_EXT_ZERO = 4'h0;
    localparam logic [SRC_IDX_W-1:0] SRC_EXT_ONE = 4'h2;

    // ==========================================================
    // Response timing in core clock cycles
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam int FASTEST_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
    localparam int RETURN_CYCLES = 5;
    localparam int DIVIDE_CYCLES = 8;
    localparam int WORST_RESPONSE = DETECT_CYCLES + RETURN_CYCLES + DIVIDE_CYCLES
        + CALL_CYCLES;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic wr;
        logic bit_wr;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [7:0] wdata;
        logic rd;
    } sfr_req_s;

    typedef struct packed {
        logic [2:0] pin_sel;
        logic polarity;
        logic edge_sel;
    } ext_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALL = 3'b010,
        ST_RETURN_HOLD = 3'b100
    } arb_state_e;

endpackage

/* verilog/two_level_interrupt_controller.sv */
`timescale 1ns/1ns
// What this block does
// [RULE_01] Sixteen sources, each with a pending flag and its own vector.
// [RULE_02] A pending flag set by software requests exactly like hardware.
// [RULE_03] Each source has a priority bit; low priority after reset.
// [RULE_04] High requests preempt low handlers; high handlers are never preempted.
// [RULE_05] Simultaneous requests: higher level first, fixed order breaks ties.
// [RULE_06] Requests sampled every cycle; one detect cycle then a four-cycle call.
// [RULE_07] After a return, one more instruction completes before the next call.
// [RULE_08] Worst response eighteen cycles: detect, return, divide, call.
// [RULE_09] A request waits behind an equal or higher running handler.
// [RULE_10] Priority register bit 7 reads one and ignores writes.
// [RULE_11] Priority bits 6..0: serial, timer2, uart, timer1, ext1, timer0, ext0.
// [RULE_12] Priority register seen on every page, bit and byte writable.
// [RULE_13] Each external input has polarity: zero active low, one active high.
// [RULE_14] Each external input selects edge (one) or level (zero) sensing.
// [RULE_15] External inputs watch pins without disturbing routed peripherals.
// [RULE_16] External pending flags sit at timer control bits one and three.
// [RULE_17] Edge mode clears the external pending flag when the CPU vectors.
// [RULE_18] Level mode pending flag follows the active state of the input.
// [RULE_19] A level source holds its request until it is recognised.
// [RULE_20] A level source drops its request before its handler ends.
// [RULE_21] Three-bit pin select per external input picks port-zero pin 0..7.
// [RULE_22] Tie order ascends by vector index, external input zero first.
module two_level_interrupt_controller
    import irq_ctrl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire sfr_req_s sfr_i,
    input wire logic [PIN_COUNT-1:0] port_pins_i,
    input wire logic [SRC_COUNT-1:0] periph_pending_i,
    input wire logic [SRC_COUNT-1:0] src_enable_i,
    input wire logic cpu_vector_ack_i,
    input wire logic cpu_return_done_i,
    input wire logic cpu_instr_done_i,
    output logic [7:0] sfr_rdata_o,
    output logic irq_req_o,
    output logic [SRC_IDX_W-1:0] irq_vec_o,
    output logic irq_high_o,
    output logic [1:0] in_service_o,
    output logic [1:0] ext_pending_o
);

    typedef struct packed {
        arb_state_e arb;

        logic [PRIO_USED_BITS-1:0] source_prio;
        logic [EXTENDED_PRIO_BITS-1:0] extended_prio;
        logic extended_prio_b;
        logic [7:0] ext_cfg;
        logic ext_zero_edge_sel;
        logic ext_one_edge_sel;

        logic [7:0] rdata;

        logic req;
        logic [SRC_IDX_W-1:0] vec;
        logic high;

        logic serv_high;
        logic serv_low;
    } ctrl_state_s;

    ctrl_state_s state;
    ctrl_state_s next_state;

    logic ext_zero_pending;
    logic ext_one_pending;

    logic ext_zero_sw_write;
    logic ext_one_sw_write;

    logic ext_zero_sw_value;
    logic ext_one_sw_value;

    logic ext_zero_vec_clr;
    logic ext_one_vec_clr;

    logic [SRC_COUNT-1:0] pending_all;
    logic [SRC_COUNT-1:0] prio_all;

    logic [SRC_COUNT-1:0] cand_high;
    logic [SRC_COUNT-1:0] cand_low;

    logic win_valid;
    logic win_high;
    logic [SRC_IDX_W-1:0] win_src;

    logic [7:0] timer_control_reg_view;
    logic [7:0] timer_control_reg_new;
    logic timer_control_reg_write;

    logic [7:0] prio_wr;
    logic [7:0] prio_b_wr;

    logic accept;

    // ==========================================================
    // Register access helpers
    function automatic logic [7:0] apply_write(input logic [7:0] old, input sfr_req_s req,
                                               input logic bit_ok);
        logic [7:0] val;
        val = old;

        if (req.wr) begin
            val = req.wdata;
        end else if (req.bit_wr && bit_ok) begin
            val[req.bit_idx] = req.bit_val;
        end
        return val;
    endfunction

    function automatic logic hits(input sfr_req_s req, input logic [7:0] addr);
        return (req.wr || req.bit_wr || req.rd) && (req.addr == addr);
    endfunction

    // Lowest set index wins, giving the fixed ascending tie order.
    function automatic logic [SRC_IDX_W-1:0] first_set(input logic [SRC_COUNT-1:0] v);
        logic [SRC_IDX_W-1:0] idx;
        idx = '0;

        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = SRC_IDX_W'(i); // [RULE_22] [RULE_05]
            end
        end
        return idx;
    endfunction

    // ==========================================================
    // External inputs
    assign timer_control_reg_view = {4'h0, ext_one_pending, state.ext_one_edge_sel,
                        ext_zero_pending, state.ext_zero_edge_sel}; // [RULE_16]

    assign timer_control_reg_write = hits(sfr_i, ADDR_TIMER_CONTROL) && (sfr_i.wr || sfr_i.bit_wr);
    assign timer_control_reg_new = apply_write(timer_control_reg_view, sfr_i, 1'b1);
    // Bit 7 is rebuilt as one, so no write can clear it.
    assign prio_wr = apply_write({1'b1, state.source_prio}, sfr_i, 1'b1);
    assign prio_b_wr = apply_write({7'h00, state.extended_prio_b}, sfr_i, 1'b0);

    assign ext_zero_sw_write = timer_control_reg_write; // [RULE_02]
    assign ext_one_sw_write = timer_control_reg_write; // [RULE_02]
    assign ext_zero_sw_value = timer_control_reg_new[TIMER_CONTROL_REG_EXT_ZERO_PENDING];
    assign ext_one_sw_value = timer_control_reg_new[TIMER_CONTROL_REG_EXT_ONE_PENDING];

    assign accept = (state.arb == ST_CALL) && state.req && cpu_vector_ack_i;
    assign ext_zero_vec_clr = accept && (state.vec == SRC_EXT_ZERO); // [RULE_17]
    assign ext_one_vec_clr = accept && (state.vec == SRC_EXT_ONE); // [RULE_17]

    ext_input_detect ext_zero (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .port_pins_i(port_pins_i),
        .cfg_i('{pin_sel: state.ext_cfg[CFG_ZERO_PIN_SEL_LSB +: 3],
                 polarity: state.ext_cfg[CFG_ZERO_POLARITY],
                 edge_sel: state.ext_zero_edge_sel}),
        .sw_write_i(ext_zero_sw_write),
        .sw_value_i(ext_zero_sw_value),
        .vector_clr_i(ext_zero_vec_clr),
        .pending_o(ext_zero_pending)
    );

    ext_input_detect ext_one (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .port_pins_i(port_pins_i),
        .cfg_i('{pin_sel: state.ext_cfg[CFG_ONE_PIN_SEL_LSB +: 3],
                 polarity: state.ext_cfg[CFG_ONE_POLARITY],
                 edge_sel: state.ext_one_edge_sel}),
        .sw_write_i(ext_one_sw_write),
        .sw_value_i(ext_one_sw_value),
        .vector_clr_i(ext_one_vec_clr),
        .pending_o(ext_one_pending)
    );

    // ==========================================================
    // Arbitration, re-evaluated every cycle
    always_comb begin
        pending_all = periph_pending_i; // [RULE_01]

        pending_all[SRC_EXT_ZERO] = ext_zero_pending;
        pending_all[SRC_EXT_ONE] = ext_one_pending;
    end

    assign prio_all = {state.extended_prio_b, state.extended_prio, state.source_prio}; // [RULE_03]
    assign cand_high = pending_all & src_enable_i & prio_all;
    assign cand_low = pending_all & src_enable_i & ~prio_all;

    always_comb begin
        win_valid = 1'b0;
        win_high = 1'b0;
        win_src = '0;

        // High handlers block everything; low handlers block only low requests.
        if ((cand_high != '0) && !state.serv_high) begin
            win_valid = 1'b1; // [RULE_04] [RULE_05]
            win_high = 1'b1;
            win_src = first_set(cand_high);
        end else if ((cand_low != '0) && !state.serv_high && !state.serv_low) begin
            win_valid = 1'b1; // [RULE_09]
            win_src = first_set(cand_low);
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;

        // Register writes.
        if (hits(sfr_i, ADDR_SOURCE_PRIO)) begin
            next_state.source_prio = prio_wr[PRIO_USED_BITS-1:0]; // [RULE_12] [RULE_11]
        end

        if (hits(sfr_i, ADDR_EXTENDED_PRIO)) begin
            next_state.extended_prio = apply_write(state.extended_prio, sfr_i, 1'b0);
        end

        if (hits(sfr_i, ADDR_EXTENDED_PRIO_B)) begin
            next_state.extended_prio_b = prio_b_wr[0];
        end

        if (hits(sfr_i, ADDR_EXT_INPUT_CFG) && (sfr_i.page == PAGE_EXT_INPUT_CFG)) begin
            next_state.ext_cfg = apply_write(state.ext_cfg, sfr_i, 1'b0); // [RULE_21]
        end

        if (timer_control_reg_write) begin
            next_state.ext_zero_edge_sel = timer_control_reg_new[TIMER_CONTROL_REG_EXT_ZERO_EDGE_SEL]; // [RULE_14]
            next_state.ext_one_edge_sel = timer_control_reg_new[TIMER_CONTROL_REG_EXT_ONE_EDGE_SEL];
        end

        // Register reads, answered one cycle later.
        if (sfr_i.rd) begin
            unique case (sfr_i.addr)
                ADDR_SOURCE_PRIO: next_state.rdata = {1'b1, state.source_prio}; // [RULE_10]
                ADDR_EXTENDED_PRIO: next_state.rdata = state.extended_prio;
                ADDR_EXTENDED_PRIO_B: next_state.rdata = {7'h00, state.extended_prio_b};
                ADDR_TIMER_CONTROL: next_state.rdata = timer_control_reg_view; // [RULE_16]
                ADDR_EXT_INPUT_CFG: begin
                    next_state.rdata = (sfr_i.page == PAGE_EXT_INPUT_CFG) ?
                        state.ext_cfg : READ_ZERO;
                end
                default: next_state.rdata = READ_ZERO;
            endcase
        end

        // A return retires the most urgent handler in service.
        if (cpu_return_done_i) begin
            if (state.serv_high) begin
                next_state.serv_high = 1'b0;
            end else begin
                next_state.serv_low = 1'b0;
            end
        end

        unique case (state.arb)
            ST_IDLE: begin
                if (cpu_return_done_i) begin
                    next_state.arb = ST_RETURN_HOLD; // [RULE_07]
                end else if (win_valid) begin
                    next_state.arb = ST_CALL; // [RULE_06]
                    next_state.req = 1'b1;
                    next_state.vec = win_src;
                    next_state.high = win_high;
                end
            end

            ST_CALL: begin
                if (accept) begin
                    next_state.arb = ST_IDLE;
                    next_state.req = 1'b0;
                    if (state.high) begin
                        next_state.serv_high = 1'b1; // [RULE_04]
                    end else begin
                        next_state.serv_low = 1'b1; // [RULE_09]
                    end
                end else if (cpu_return_done_i) begin
                    next_state.arb = ST_RETURN_HOLD; // [RULE_07] [RULE_08]
                    next_state.req = 1'b0;
                end else if (win_valid) begin
                    // Until the call the request follows the current winner; it is dropped on a completed return or when no winner remains.
                    next_state.vec = win_src; // [RULE_05]
                    next_state.high = win_high;
                end else begin
                    next_state.arb = ST_IDLE; // [RULE_19]
                    next_state.req = 1'b0;
                end
            end

            ST_RETURN_HOLD: begin
                if (cpu_instr_done_i) begin
                    next_state.arb = ST_IDLE; // [RULE_07] [RULE_20]
                end
            end

            default: begin
                next_state.arb = ST_IDLE;
                next_state.req = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state.arb <= ST_IDLE;

            state.source_prio <= SOURCE_PRIO_RESET[PRIO_USED_BITS-1:0]; // [RULE_03]
            state.extended_prio <= EXTENDED_PRIO_RESET;
            state.extended_prio_b <= 1'b0;
            state.ext_cfg <= EXT_INPUT_CFG_RESET;
            state.ext_zero_edge_sel <= TIMER_CONTROL_RESET[TIMER_CONTROL_REG_EXT_ZERO_EDGE_SEL];
            state.ext_one_edge_sel <= TIMER_CONTROL_RESET[TIMER_CONTROL_REG_EXT_ONE_EDGE_SEL];

            state.rdata <= READ_ZERO;
            state.req <= 1'b0;
            state.vec <= '0;
            state.high <= 1'b0;

            state.serv_high <= 1'b0;
            state.serv_low <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs
    assign sfr_rdata_o = state.rdata;

    assign irq_req_o = state.req;
    assign irq_vec_o = state.vec;
    assign irq_high_o = state.high;
    assign in_service_o = {state.serv_high, state.serv_low};

    assign ext_pending_o = {ext_one_pending, ext_zero_pending};

endmodule
